// ---- logic/lsc_link_sync.sv ----
// Link sync response: drives code group sync and lane alignment start-up.
//
// Overview of operation
// - The single-ended sync input is active low and starts the 8B/10B link when the selector is 0.
// - In 64B/66B modes the sync request is ignored and start-up never depends on its level.
// - In 8B/10B modes a low sync request starts code group synchronization on the lanes.
// - After synchronization the receiver raises sync and the device then sends the lane alignment sequence.
// - The sync request can come from the timestamp input or the alternate sync pin instead.
`timescale 1ns/1ps
`default_nettype none
module lsc_link_sync
    import lsc_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Configuration, from logic on this clock
    input wire logic i_enc_64b66b,
    input wire logic [1:0] i_sync_sel,
    input wire logic i_link_en,
    input wire logic i_ilas_done,
    // Sync pins, asynchronous
    input wire logic i_single_ended_link_sync_in,
    input wire logic i_timestamp_input,
    input wire logic i_alt_link_sync_in,
    // Status
    output lsc_status_t o_status,
    output logic o_sync_req
);

    logic se_sync;
    logic ts_sync;
    logic alt_sync;
    lsc_state_t state;
    lsc_state_t next_state;
    logic [LSC_CNT_W-1:0] cgs_cnt;
    logic [LSC_CNT_W-1:0] next_cgs_cnt;
    lsc_status_t next_status;

    lsc_sync2 #(.RST_VAL(1'b1)) u_sync_se (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_single_ended_link_sync_in),
        .o_q(se_sync)
    );

    lsc_sync2 #(.RST_VAL(1'b1)) u_sync_ts (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_timestamp_input),
        .o_q(ts_sync)
    );

    lsc_sync2 #(.RST_VAL(1'b1)) u_sync_alt (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_d(i_alt_link_sync_in),
        .o_q(alt_sync)
    );

    // Unselected pins may be tied low on the board, so only the chosen source is looked at.
    function automatic logic pick_sync(
        input logic [1:0] sel,
        input logic se_lvl,
        input logic ts_lvl,
        input logic alt_lvl
    );
        logic lvl;
        lvl = 1'b1;
        case (sel)
            LSC_SRC_SE:
            begin
                lvl = se_lvl;
            end
            LSC_SRC_TS:
            begin
                lvl = ts_lvl;
            end
            LSC_SRC_ALT:
            begin
                lvl = alt_lvl;
            end
            default:
            begin
                lvl = 1'b1;
            end
        endcase
        return lvl;
    endfunction

    // A request only counts in 8B/10B; in 64B/66B the pin level is a don't-care.
    function automatic logic wants_cgs(
        input logic enc_64b66b,
        input logic req
    );
        return !enc_64b66b && req;
    endfunction

    function automatic lsc_status_t status_of(
        input lsc_state_t st
    );
        lsc_status_t s;
        s = LSC_STATUS_RST;
        s.cgs = (st == LSC_ST_CGS);
        s.ilas = (st == LSC_ST_ILAS);
        s.data = (st == LSC_ST_DATA);
        return s;
    endfunction

    wire logic sel_sync = pick_sync(i_sync_sel, se_sync, ts_sync, alt_sync);
    wire logic sync_req = !sel_sync;
    wire logic req_8b10b = wants_cgs(i_enc_64b66b, sync_req);
    wire logic cgs_done = (cgs_cnt >= LSC_CGS_DONE_CNT);
    wire logic [LSC_CNT_W-1:0] cgs_cnt_inc = cgs_cnt + LSC_CNT_ONE;
    wire logic stay_cgs = (state == LSC_ST_CGS) && (next_state == LSC_ST_CGS);

    assign next_status = status_of(next_state);

    always_comb
    begin
        next_state = state;
        case (state)
            LSC_ST_IDLE:
            begin
                if (i_link_en && i_enc_64b66b)
                begin
                    next_state = LSC_ST_DATA;
                end
                else if (i_link_en && req_8b10b)
                begin
                    next_state = LSC_ST_CGS;
                end
            end
            LSC_ST_CGS:
            begin
                // The minimum stay is counted first, so an early release is held off.
                if (i_enc_64b66b)
                begin
                    next_state = LSC_ST_DATA;
                end
                else if (cgs_done && !sync_req)
                begin
                    next_state = LSC_ST_ILAS;
                end
            end
            LSC_ST_ILAS:
            begin
                if (req_8b10b)
                begin
                    next_state = LSC_ST_CGS;
                end
                else if (i_ilas_done)
                begin
                    next_state = LSC_ST_DATA;
                end
            end
            LSC_ST_DATA:
            begin
                // A fresh request in 8B/10B restarts the link; 64B/66B never looks.
                if (req_8b10b)
                begin
                    next_state = LSC_ST_CGS;
                end
            end
            default:
            begin
                next_state = LSC_ST_IDLE;
            end
        endcase
        if (!i_link_en)
        begin
            next_state = LSC_ST_IDLE;
        end
    end

    // The count restarts from zero on every entry into code group sync.
    always_comb
    begin
        next_cgs_cnt = LSC_CNT_ZERO;
        if (stay_cgs && !cgs_done)
        begin
            next_cgs_cnt = cgs_cnt_inc;
        end
        else if (stay_cgs)
        begin
            next_cgs_cnt = cgs_cnt;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state <= LSC_ST_IDLE;
            cgs_cnt <= LSC_CNT_ZERO;
        end
        else
        begin
            state <= next_state;
            cgs_cnt <= next_cgs_cnt;
        end
    end

    // Status is registered from the next state so it lines up with the state register.
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_status <= LSC_STATUS_RST;
            o_sync_req <= 1'b0;
        end
        else
        begin
            o_status <= next_status;
            o_sync_req <= req_8b10b;
        end
    end

endmodule
`default_nettype wire

// ---- logic/lsc_pkg.sv ----
// Package with types and constants for the link sync start-up control block.
package lsc_pkg;

    // Sync source selector encodings.
    localparam logic [1:0] LSC_SRC_SE = 2'h0;
    localparam logic [1:0] LSC_SRC_TS = 2'h1;
    localparam logic [1:0] LSC_SRC_ALT = 2'h2;

    // Minimum count of clock cycles spent in code group sync before it counts as done.
    localparam int unsigned LSC_CGS_MIN_NS = 200;
    localparam int unsigned LSC_CLK_MHZ = 20;
    localparam int unsigned LSC_CGS_CYC_RAW = (LSC_CGS_MIN_NS * LSC_CLK_MHZ + 999) / 1000;
    localparam int unsigned LSC_CGS_CYC = (LSC_CGS_CYC_RAW < 1) ? 1 : LSC_CGS_CYC_RAW;
    localparam int LSC_CNT_W = 4;
    localparam logic [LSC_CNT_W-1:0] LSC_CNT_ZERO = 4'h0;
    localparam logic [LSC_CNT_W-1:0] LSC_CNT_ONE = 4'h1;
    localparam logic [LSC_CNT_W-1:0] LSC_CGS_DONE_CNT = LSC_CNT_W'(LSC_CGS_CYC);

    // Link start-up states, Gray coded along the usual path.
    typedef enum logic [1:0] {
        LSC_ST_IDLE = 2'b00,
        LSC_ST_CGS = 2'b01,
        LSC_ST_ILAS = 2'b11,
        LSC_ST_DATA = 2'b10
    } lsc_state_t;

    // Link start-up status carried out of the block together.
    typedef struct packed {
        logic cgs;
        logic ilas;
        logic data;
    } lsc_status_t;

    localparam lsc_status_t LSC_STATUS_RST = 3'h0;

endpackage

// ---- logic/lsc_sync2.sv ----
// Two-flop synchroniser for the external sync pins.
`timescale 1ns/1ps
`default_nettype none
module lsc_sync2
    import lsc_pkg::*;
#(
    parameter logic RST_VAL = 1'b1
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // Data
    input wire logic i_d,
    output logic o_q
);

    logic meta;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            meta <= RST_VAL;
            o_q <= RST_VAL;
        end
        else
        begin
            meta <= i_d;
            o_q <= meta;
        end
    end

endmodule
`default_nettype wire

// ---- sim/lsc_link_sync_sva.sv ----
// Concurrent checks on the link sync block ports.
`timescale 1ns/1ps
`default_nettype none
module lsc_link_sync_sva
    import lsc_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_enc_64b66b,
    input wire logic [1:0] i_sync_sel,
    input wire logic i_link_en,
    input wire logic i_single_ended_link_sync_in,
    input wire lsc_status_t o_status,
    input wire logic o_sync_req
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    wire logic go = i_link_en && !i_enc_64b66b;
    chk_se_req: assert property ((go && !i_sync_sel && !i_single_ended_link_sync_in)[*4] |-> o_sync_req)
        else $error("low pin missed");
    chk_req_off: assert property ((i_sync_sel == 2'h3 || i_enc_64b66b)[*4] |-> !o_sync_req) else $error("stray");
    chk_req_cgs: assert property ($rose(o_sync_req) && $past(go) && go |-> o_status.cgs) else $error("no cgs");
    chk_align_in: assert property ($rose(o_status.ilas) |-> $past(o_status.cgs) && !o_sync_req) else $error("early");
    chk_cgs_hold: assert property (o_status.cgs && go ##1 o_sync_req |-> o_status.cgs) else $error("left cgs");
    chk_cgs_min: assert property ($rose(o_status.cgs) ##0 go[*4] |-> o_status.cgs) else $error("short cgs");
    cover property ($rose(o_status.cgs));
    cover property ($rose(o_status.ilas));
    cover property ($rose(o_status.data));
endmodule
bind lsc_link_sync lsc_link_sync_sva chk (.*);
`default_nettype wire

// ---- sim/lsc_link_sync_tb.sv ----
// Bench for the link sync block.
`timescale 1ns/1ps
`default_nettype none
module lsc_link_sync_tb;
    import lsc_pkg::*;
    logic i_clk = 1'b0, i_rst_n = 1'b0, i_enc_64b66b = 1'b0, i_link_en = 1'b0, i_ilas_done = 1'b0;
    logic [1:0] i_sync_sel = 2'h0;
    logic sync_n, o_sync_req, i_single_ended_link_sync_in, i_timestamp_input, i_alt_link_sync_in;
    lsc_status_t o_status;
    int errors = 0, samples_checked = 0, n;
    assign {i_alt_link_sync_in, i_timestamp_input, i_single_ended_link_sync_in} = {3{sync_n}} & (3'h1 << i_sync_sel);
    lsc_link_sync uut (.*);
    lsc_rx_model rx (.i_clk, .i_hold(i_link_en ? {i_sync_sel, 2'h1} : 4'h0), .i_cgs(o_status.cgs), .o_sync_n(sync_n));
    initial forever #25 i_clk = ~i_clk;
    task automatic check(input logic [2:0] seen, input logic [2:0] exp);
        samples_checked++;
        errors += 32'(seen !== exp);
        if (seen !== exp)
            $display("unexpected %0t got %b want %b", $time, seen, exp);
    endtask
    task automatic stop_test;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic run(input logic [1:0] sel);
        {i_sync_sel, i_link_en, i_ilas_done} = {sel, 2'h3};
        for (n = 0; n < 20 && o_status !== 3'h4; n++) @(negedge i_clk);
        check({1'b0, o_status.cgs, o_sync_req}, 3'h3);
        for (n = 0; n < 30 && o_status.cgs; n++) @(negedge i_clk);
        check({2'(n > 4 * sel + 1 && n >= LSC_CGS_CYC), o_status.ilas}, 3'h3);
        @(negedge i_clk);
        check(o_status, 3'h1);
        {i_ilas_done, i_link_en} = 2'h0;
        repeat (2) @(negedge i_clk);
    endtask
    task automatic quiet;
        {i_sync_sel, i_link_en} = 3'h7;
        repeat (8) @(negedge i_clk);
        check(o_status, 3'h0);
        {i_sync_sel, i_enc_64b66b} = 3'h1;
        repeat (4) @(negedge i_clk);
        check({o_status[1:0], o_sync_req}, 3'h2);
    endtask
    initial
    begin
        repeat (3) @(negedge i_clk);
        i_rst_n = 1'b1;
        for (int s = 0; s < 3; s++) run(2'(s));
        quiet;
        stop_test;
    end
    initial
    begin
        repeat (4000) @(posedge i_clk);
        errors++;
        stop_test;
    end
endmodule
`default_nettype wire

// ---- sim/lsc_rx_model.sv ----
// Receiver model: holds sync low until code group sync has run i_hold cycles.
`timescale 1ns/1ps
`default_nettype none
module lsc_rx_model (
    input wire logic i_clk,
    input wire logic [3:0] i_hold,
    input wire logic i_cgs,
    output logic o_sync_n
);
    logic [3:0] seen = 4'h0;
    always @(negedge i_clk)
        seen <= (i_hold != 4'h0) ? seen + 4'(i_cgs) : 4'h0;
    assign o_sync_n = seen >= i_hold;
endmodule
`default_nettype wire
